// *** verilog/mpm_pin_clock_mux.sv ***
`timescale 1ns/100ps
// Operation
// - Modulator clock runs only while divide and range bits are both zero.
// - Speed bit picks modulator clock of reference/2 or reference/4.
// - One modulator clock output, toggled only on reference edges.
// - Four shared pins: select, sync, data and clock, function by mode.
// - Stand-alone mode drives negative power on the sync pin.
// - Stand-alone mode drives tamper on the data pin.
// - Stand-alone mode drives no-load on the clock pin.
// - Stand-alone mode puts total power pulse train on the pulse pin.
// - Peripheral mode enables the serial port for the microcontroller.
// - Reset leaves the block in peripheral mode.
// - Peripheral mode drives watchdog reset on the negative monitor.
// - Peripheral mode drives zero crossing on the positive monitor.
// - Peripheral mode drives programmable energy pulse on the pulse pin.
module mpm_pin_clock_mux (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Configuration bits
    input wire logic standalone_select_bit,
    input wire logic modulator_clock_speed_bit,
    input wire logic reference_divide_bit,
    input wire logic frequency_range_bit,
    // Crystal reference, sampled
    input wire logic reference_clock_pin,
    // Modulator clock and status
    output logic modulator_clock_pin,
    output logic clock_config_error,
    output logic standalone_active,
    // Multi-purpose pins
    input wire logic serial_select_pin,
    input wire logic sync_or_negative_power_pin_in,
    output logic sync_or_negative_power_pin_out,
    output logic sync_or_negative_power_pin_oe,
    input wire logic serial_data_or_tamper_pin_in,
    output logic serial_data_or_tamper_pin_out,
    output logic serial_data_or_tamper_pin_oe,
    input wire logic serial_clock_or_no_load_pin_in,
    output logic serial_clock_or_no_load_pin_out,
    output logic serial_clock_or_no_load_pin_oe,
    // Monitor and pulse pins
    output logic negative_monitor_pin,
    output logic positive_monitor_pin,
    output logic energy_pulse_pin,
    // Stand-alone sources
    input wire logic negative_power,
    input wire logic tamper_detected,
    input wire logic no_load_detected,
    input wire logic total_power_pulse,
    // Peripheral sources
    input wire logic watchdog_reset,
    input wire logic zero_crossing_flag,
    input wire logic programmable_energy_pulse,
    // Serial protocol side
    input wire logic spi_data_out,
    input wire logic spi_data_out_en,
    output logic spi_select,
    output logic spi_sync,
    output logic spi_data_in,
    output logic spi_clock
);
    import mpm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mpm_mode_e mode;
        logic [PIN_COUNT-1:0] s0;
        logic [PIN_COUNT-1:0] s1;
        logic [PIN_COUNT-1:0] s2;
        logic [PIN_COUNT-1:0] stable;
        logic [1:0] edge_cnt;
        logic mclk;
        logic cfg_err;
        logic syn_out;
        logic syn_oe;
        logic sda_out;
        logic sda_oe;
        logic scl_out;
        logic scl_oe;
        logic neg_monitor;
        logic pos_monitor;
        logic pulse;
        logic spi_sel;
        logic spi_syn;
        logic spi_sda;
        logic spi_scl;
    } mpm_state_s;

    mpm_state_s state_reg;
    mpm_state_s state_next;
    logic [PIN_COUNT-1:0] pin_vec;
    logic [PIN_COUNT-1:0] agree;
    logic ref_rise;
    logic cfg_ok;
    logic [1:0] half_edges;
    logic periph;

    // Raw pins gathered for the common synchroniser
    assign pin_vec = {reference_clock_pin,
                      serial_clock_or_no_load_pin_in,
                      serial_data_or_tamper_pin_in,
                      sync_or_negative_power_pin_in,
                      serial_select_pin};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        // Mode follows the select bit; reset value is peripheral
        state_next.mode = standalone_select_bit ? MPM_MODE_STANDALONE
                                                : MPM_MODE_PERIPH;
        // Three stages; a level counts once stages two and three agree
        state_next.s0 = pin_vec;
        state_next.s1 = state_reg.s0;
        state_next.s2 = state_reg.s1;
        agree = ~(state_reg.s1 ^ state_reg.s2);
        state_next.stable = (agree & state_reg.s2)
                          | (~agree & state_reg.stable);
        ref_rise = state_next.stable[PIN_REF]
                 & ~state_reg.stable[PIN_REF];
        // Nonzero divide or range bits mean the wrong reference rate
        cfg_ok = ~reference_divide_bit & ~frequency_range_bit;
        state_next.cfg_err = ~cfg_ok;
        half_edges = modulator_clock_speed_bit ? FAST_HALF_EDGES
                                               : SLOW_HALF_EDGES;
        // Single shared clock, stepped only on reference edges
        if (!cfg_ok) begin
            state_next.edge_cnt = EDGE_CNT_RESET;
            state_next.mclk = MCLK_RESET;
        end else if (ref_rise) begin
            if (2'(state_reg.edge_cnt + 2'h1) >= half_edges) begin
                state_next.edge_cnt = EDGE_CNT_RESET;
                state_next.mclk = ~state_reg.mclk;
            end else begin
                state_next.edge_cnt = 2'(state_reg.edge_cnt + 2'h1);
            end
        end
        // Pin sources chosen from the current mode
        periph = (state_reg.mode == MPM_MODE_PERIPH);
        if (periph) begin
            // Serial port live; sync and clock are inputs here
            state_next.syn_out = 1'b0;
            state_next.syn_oe = 1'b0;
            state_next.sda_out = spi_data_out;
            state_next.sda_oe = spi_data_out_en;
            state_next.scl_out = 1'b0;
            state_next.scl_oe = 1'b0;
            state_next.neg_monitor = watchdog_reset;
            state_next.pos_monitor = zero_crossing_flag;
            state_next.pulse = programmable_energy_pulse;
            state_next.spi_sel = state_reg.stable[PIN_SEL];
            state_next.spi_syn = state_reg.stable[PIN_SYN];
            state_next.spi_sda = state_reg.stable[PIN_SDA];
            state_next.spi_scl = state_reg.stable[PIN_SCL];
        end else begin
            state_next.syn_out = negative_power;
            state_next.syn_oe = 1'b1;
            state_next.sda_out = tamper_detected;
            state_next.sda_oe = 1'b1;
            state_next.scl_out = no_load_detected;
            state_next.scl_oe = 1'b1;
            // Monitors have no stand-alone role; parked low
            state_next.neg_monitor = 1'b0;
            state_next.pos_monitor = 1'b0;
            state_next.pulse = total_power_pulse;
            // Protocol sees idle lines so stray host activity is ignored
            state_next.spi_sel = 1'b0;
            state_next.spi_syn = 1'b0;
            state_next.spi_sda = 1'b0;
            state_next.spi_scl = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_reg <= '0;
            state_reg.mode <= MODE_RESET;
            state_reg.s0 <= SYNC_RESET;
            state_reg.s1 <= SYNC_RESET;
            state_reg.s2 <= SYNC_RESET;
            state_reg.stable <= SYNC_RESET;
            state_reg.edge_cnt <= EDGE_CNT_RESET;
            state_reg.mclk <= MCLK_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Every output straight from the state register
    assign modulator_clock_pin = state_reg.mclk;
    assign clock_config_error = state_reg.cfg_err;
    assign standalone_active = state_reg.mode;
    assign sync_or_negative_power_pin_out = state_reg.syn_out;
    assign sync_or_negative_power_pin_oe = state_reg.syn_oe;
    assign serial_data_or_tamper_pin_out = state_reg.sda_out;
    assign serial_data_or_tamper_pin_oe = state_reg.sda_oe;
    assign serial_clock_or_no_load_pin_out = state_reg.scl_out;
    assign serial_clock_or_no_load_pin_oe = state_reg.scl_oe;
    assign negative_monitor_pin = state_reg.neg_monitor;
    assign positive_monitor_pin = state_reg.pos_monitor;
    assign energy_pulse_pin = state_reg.pulse;
    assign spi_select = state_reg.spi_sel;
    assign spi_sync = state_reg.spi_syn;
    assign spi_data_in = state_reg.spi_sda;
    assign spi_clock = state_reg.spi_scl;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking

    // Reference edge that stepped the modulator clock
    sequence s_toggle_rise;
        $rose(state_reg.stable[PIN_REF]) && $changed(state_reg.mclk);
    endsequence

    // Reference edge that left the modulator clock alone
    sequence s_quiet_rise;
        $rose(state_reg.stable[PIN_REF]) && $stable(state_reg.mclk);
    endsequence

    a_cfg_stops_mclk: assert property (disable iff (rst)
        (reference_divide_bit || frequency_range_bit)
        |=> (clock_config_error && !modulator_clock_pin))
        else $error("modulator clock not held by divider config");

    a_fast_every_edge: assert property (disable iff (rst)
        $rose(state_reg.stable[PIN_REF]) && $past(modulator_clock_speed_bit)
        && !clock_config_error |-> $changed(modulator_clock_pin))
        else $error("fast modulator clock missed a reference edge");

    // Judged per edge, so a speed bit that moves between edges is harmless
    a_slow_every_other: assert property (disable iff (rst)
        (s_toggle_rise ##0 !$past(modulator_clock_speed_bit)
         ##0 !clock_config_error)
        |-> $past(state_reg.edge_cnt) == 2'h1)
        else $error("slow modulator clock toggled on adjacent edges");

    // Counter at zero means this edge is the skipped one of the pair
    a_slow_quiet_edge: assert property (disable iff (rst)
        (s_quiet_rise ##0 !$past(modulator_clock_speed_bit)
         ##0 !clock_config_error)
        |-> $past(state_reg.edge_cnt) == 2'h0)
        else $error("slow modulator clock skipped a toggle");

    a_mclk_on_ref: assert property (disable iff (rst)
        $changed(modulator_clock_pin) && !clock_config_error
        && !$past(clock_config_error)
        |-> $rose(state_reg.stable[PIN_REF]))
        else $error("modulator clock moved without a reference edge");

    a_sa_negative_pwr: assert property (disable iff (rst)
        standalone_active |=> sync_or_negative_power_pin_oe
        && sync_or_negative_power_pin_out == $past(negative_power))
        else $error("negative power not on sync pin");

    a_sa_tamper_pin: assert property (disable iff (rst)
        standalone_active |=> serial_data_or_tamper_pin_oe
        && serial_data_or_tamper_pin_out == $past(tamper_detected))
        else $error("tamper not on data pin");

    a_sa_no_load: assert property (disable iff (rst)
        standalone_active |=> serial_clock_or_no_load_pin_oe
        && serial_clock_or_no_load_pin_out == $past(no_load_detected))
        else $error("no-load not on clock pin");

    a_sa_total_pulse: assert property (disable iff (rst)
        standalone_active |=> energy_pulse_pin == $past(total_power_pulse))
        else $error("total power pulse not on pulse pin");

    a_periph_port_on: assert property (disable iff (rst)
        !standalone_active |=> !sync_or_negative_power_pin_oe
        && !serial_clock_or_no_load_pin_oe
        && serial_data_or_tamper_pin_oe == $past(spi_data_out_en))
        else $error("serial port pins wrong in peripheral mode");

    a_reset_periph: assert property (
        rst |=> !standalone_active)
        else $error("reset did not select peripheral mode");

    a_periph_monitors: assert property (disable iff (rst)
        !standalone_active |=> negative_monitor_pin == $past(watchdog_reset)
        && positive_monitor_pin == $past(zero_crossing_flag))
        else $error("monitor pins wrong in peripheral mode");

    a_periph_pulse: assert property (disable iff (rst)
        !standalone_active
        |=> energy_pulse_pin == $past(programmable_energy_pulse))
        else $error("programmable pulse not on pulse pin");

    a_sa_spi_idle: assert property (disable iff (rst)
        standalone_active [*2] |=> !spi_select && !spi_sync
        && !spi_data_in && !spi_clock)
        else $error("serial inputs leak in stand-alone mode");

    a_mode_follows: assert property (disable iff (rst)
        $rose(standalone_select_bit) |=> standalone_active)
        else $error("mode did not follow select bit");

endmodule

// *** verilog/mpm_pkg.sv ***
package mpm_pkg;

    // ------------------------------------------------------------
    // Reference and modulator clock rates
    // ------------------------------------------------------------
    localparam int REF_CLK_KHZ = 4194;
    localparam int MCLK_FAST_KHZ = 2097;
    localparam int MCLK_SLOW_KHZ = 1049;
    // Reference rising edges per modulator half period, rounded
    localparam logic [1:0] FAST_HALF_EDGES =
        2'(((REF_CLK_KHZ + MCLK_FAST_KHZ / 2) / MCLK_FAST_KHZ) / 2);
    localparam logic [1:0] SLOW_HALF_EDGES =
        2'(((REF_CLK_KHZ + MCLK_SLOW_KHZ / 2) / MCLK_SLOW_KHZ) / 2);

    // ------------------------------------------------------------
    // Sampled pin positions
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 5;
    localparam int PIN_SEL = 0;
    localparam int PIN_SYN = 1;
    localparam int PIN_SDA = 2;
    localparam int PIN_SCL = 3;
    localparam int PIN_REF = 4;

    // ------------------------------------------------------------
    // Operating modes and reset values
    // ------------------------------------------------------------
    typedef enum logic {
        MPM_MODE_PERIPH = 1'b0,
        MPM_MODE_STANDALONE = 1'b1
    } mpm_mode_e;

    localparam mpm_mode_e MODE_RESET = MPM_MODE_PERIPH;
    localparam logic [PIN_COUNT-1:0] SYNC_RESET = 5'h00;
    localparam logic [1:0] EDGE_CNT_RESET = 2'h0;
    localparam logic MCLK_RESET = 1'b0;

endpackage

// *** verification/mpm_far_side.sv ***
`timescale 1ns/100ps
// ------------------------------------------------------------
// Far side: crystal reference and microcontroller pin drivers
// ------------------------------------------------------------
module mpm_far_side (
    // Microcontroller drive
    input wire logic mcu_en,
    input wire logic [3:0] mcu_bits,
    // Device side of the shared pins
    input wire logic [2:0] oe,
    input wire logic [2:0] out,
    // Resolved levels
    output logic ref_clk,
    output logic [3:0] pins
);
    // Crystal runs free, half of 238.4 ns at 4.194 MHz
    initial begin
        ref_clk = 1'b0;
        forever #119.2 ref_clk = ~ref_clk;
    end
    // Released lines float to the pull-up, never hold a stale value
    assign pins[0] = mcu_en ? mcu_bits[0] : 1'b1;
    // Device drive wins; microcontroller only drives in peripheral mode
    assign pins[3:1] = (oe & out) |
        (~oe & (mcu_en ? mcu_bits[3:1] : 3'b111));
endmodule

// *** verification/meter_mode_pin_and_clock_mux_test.sv ***
`timescale 1ns/100ps
module meter_mode_pin_and_clock_mux_test;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    typedef struct {int due; logic [14:0] v; logic [14:0] m;} mpm_note_s;
    logic core_clk, rst, standalone_select_bit, modulator_clock_speed_bit;
    logic reference_divide_bit, frequency_range_bit, reference_clock_pin;
    logic modulator_clock_pin, clock_config_error, standalone_active;
    logic serial_select_pin, sync_or_negative_power_pin_in;
    logic sync_or_negative_power_pin_out, sync_or_negative_power_pin_oe;
    logic serial_data_or_tamper_pin_in, serial_data_or_tamper_pin_out;
    logic serial_data_or_tamper_pin_oe, serial_clock_or_no_load_pin_in;
    logic serial_clock_or_no_load_pin_out, serial_clock_or_no_load_pin_oe;
    logic negative_monitor_pin, positive_monitor_pin, energy_pulse_pin;
    logic negative_power, tamper_detected, no_load_detected;
    logic total_power_pulse, watchdog_reset, zero_crossing_flag;
    logic programmable_energy_pulse, spi_data_out, spi_data_out_en;
    logic spi_select, spi_sync, spi_data_in, spi_clock, mcu_en;
    logic [3:0] mcu_bits;
    logic [14:0] obs, ev, em;
    logic [31:0] r;
    mpm_note_s q[$];
    mpm_note_s n;
    int cyc, checks, n_errors, n_mclk, seed;

    mpm_pin_clock_mux i_dut (
        .core_clk(core_clk),
        .rst(rst),
        .standalone_select_bit(standalone_select_bit),
        .modulator_clock_speed_bit(modulator_clock_speed_bit),
        .reference_divide_bit(reference_divide_bit),
        .frequency_range_bit(frequency_range_bit),
        .reference_clock_pin(reference_clock_pin),
        .modulator_clock_pin(modulator_clock_pin),
        .clock_config_error(clock_config_error),
        .standalone_active(standalone_active),
        .serial_select_pin(serial_select_pin),
        .sync_or_negative_power_pin_in(sync_or_negative_power_pin_in),
        .sync_or_negative_power_pin_out(sync_or_negative_power_pin_out),
        .sync_or_negative_power_pin_oe(sync_or_negative_power_pin_oe),
        .serial_data_or_tamper_pin_in(serial_data_or_tamper_pin_in),
        .serial_data_or_tamper_pin_out(serial_data_or_tamper_pin_out),
        .serial_data_or_tamper_pin_oe(serial_data_or_tamper_pin_oe),
        .serial_clock_or_no_load_pin_in(serial_clock_or_no_load_pin_in),
        .serial_clock_or_no_load_pin_out(serial_clock_or_no_load_pin_out),
        .serial_clock_or_no_load_pin_oe(serial_clock_or_no_load_pin_oe),
        .negative_monitor_pin(negative_monitor_pin),
        .positive_monitor_pin(positive_monitor_pin),
        .energy_pulse_pin(energy_pulse_pin),
        .negative_power(negative_power),
        .tamper_detected(tamper_detected),
        .no_load_detected(no_load_detected),
        .total_power_pulse(total_power_pulse),
        .watchdog_reset(watchdog_reset),
        .zero_crossing_flag(zero_crossing_flag),
        .programmable_energy_pulse(programmable_energy_pulse),
        .spi_data_out(spi_data_out),
        .spi_data_out_en(spi_data_out_en),
        .spi_select(spi_select),
        .spi_sync(spi_sync),
        .spi_data_in(spi_data_in),
        .spi_clock(spi_clock)
    );

    mpm_far_side i_far (
        .mcu_en(mcu_en),
        .mcu_bits(mcu_bits),
        .oe({serial_clock_or_no_load_pin_oe, serial_data_or_tamper_pin_oe,
            sync_or_negative_power_pin_oe}),
        .out({serial_clock_or_no_load_pin_out, serial_data_or_tamper_pin_out,
            sync_or_negative_power_pin_out}),
        .ref_clk(reference_clock_pin),
        .pins({serial_clock_or_no_load_pin_in, serial_data_or_tamper_pin_in,
            sync_or_negative_power_pin_in, serial_select_pin})
    );

    // Every pin-side output except the modulator clock in one word, mode bit on top
    assign obs = {standalone_active, sync_or_negative_power_pin_out,
        sync_or_negative_power_pin_oe, serial_data_or_tamper_pin_out,
        serial_data_or_tamper_pin_oe, serial_clock_or_no_load_pin_out,
        serial_clock_or_no_load_pin_oe, negative_monitor_pin,
        positive_monitor_pin, energy_pulse_pin, spi_select, spi_sync,
        spi_data_in, spi_clock, clock_config_error};

    // 50 MHz core clock
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    // Modulator clock rising edges, cleared by each rate window
    always @(posedge modulator_clock_pin) n_mclk++;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic note(input int due, input logic [14:0] v,
                        input logic [14:0] m);
        q.push_back('{due, v, m});
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    task automatic fail(input string s);
        n_errors++;
        $display("CHECK FAILED t=%0t %s", $time, s);
    endtask

    task automatic end_sim;
        $display("checks=%0d errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // One random step in a mode; 9 cycles cover mode switch plus sync chain
    task automatic step(input logic mode);
        logic sd;
        logic er;
        r = $random(seed);
        {modulator_clock_speed_bit, reference_divide_bit, frequency_range_bit,
            negative_power, tamper_detected, no_load_detected,
            total_power_pulse, watchdog_reset, zero_crossing_flag,
            programmable_energy_pulse, spi_data_out, spi_data_out_en,
            mcu_bits} = r[15:0];
        standalone_select_bit = mode;
        mcu_en = ~mode;
        er = reference_divide_bit | frequency_range_bit;
        em = 15'h7FFF;
        if (mode) begin
            ev = {3'b111, tamper_detected, 1'b1, no_load_detected, 3'b100,
                total_power_pulse, 4'h0, er};
            ev[13] = negative_power;
        end else begin
            sd = spi_data_out_en ? spi_data_out : mcu_bits[2];
            ev = {3'b000, spi_data_out, spi_data_out_en, 2'b00,
                watchdog_reset, zero_crossing_flag, programmable_energy_pulse,
                mcu_bits[0], mcu_bits[1], sd, mcu_bits[3], er};
            em = 15'h77FF | {3'h0, spi_data_out_en, 11'h000};
        end
        note(cyc + 8, ev, em);
        tick(9);
    endtask

    // Counts modulator clock edges over 2000 core cycles (40 us)
    task automatic mclk_run(input logic [2:0] cfg, input int lo, input int hi);
        {modulator_clock_speed_bit, reference_divide_bit,
            frequency_range_bit} = cfg;
        tick(50);
        n_mclk = 0;
        tick(2000);
        checks++;
        if (n_mclk < lo || n_mclk > hi) fail("modulator clock rate");
        checks++;
        if (cfg[1:0] != 2'b00 && (modulator_clock_pin !== 1'b0 ||
            clock_config_error !== 1'b1)) fail("clock not held low");
        $display("clock test %b done, %0d edges", cfg, n_mclk);
    endtask

    // ------------------------------------------------------------
    // Result watcher: oldest note is compared when it falls due
    // ------------------------------------------------------------
    initial begin
        forever begin
            @(posedge core_clk);
            cyc++;
            #2;
            while (q.size() > 0 && q[0].due <= cyc) begin
                n = q.pop_front();
                checks++;
                if (((obs ^ n.v) & n.m) !== 15'h0000) begin
                    fail($sformatf("pins exp %h got %h", n.v, obs));
                end
            end
        end
    end

    // Hang guard, well past the ~8400 cycles the tests need
    initial begin
        #(20 * 12000);
        fail("watchdog expired");
        end_sim;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 93;
        rst = 1'b1;
        mcu_en = 1'b1;
        mcu_bits = 4'h0;
        standalone_select_bit = 1'b0;
        {modulator_clock_speed_bit, reference_divide_bit, frequency_range_bit,
            negative_power, tamper_detected, no_load_detected,
            total_power_pulse, watchdog_reset, zero_crossing_flag,
            programmable_energy_pulse, spi_data_out,
            spi_data_out_en} = 12'h000;
        tick(10);
        rst = 1'b0;
        note(cyc + 1, 15'h0000, 15'h7FFF);
        tick(3);
        $display("reset test done");
        repeat (10) step(1'b0);
        $display("peripheral test done");
        repeat (10) step(1'b1);
        $display("stand-alone test done");
        repeat (2) step(1'b0);
        $display("mode return test done");
        mclk_run(3'b100, 82, 86);
        mclk_run(3'b000, 40, 44);
        mclk_run(3'b110, 0, 0);
        mclk_run(3'b101, 0, 0);
        end_sim;
    end
endmodule
